// file: common/lsp_pkg.sv
/*
 * Package for the lane sample packer: mode indices, widths and the
 * carriers for input samples and the lane words.
 * Assumes a single 200 MHz clock domain with no software registers.
 */
package lsp_pkg;
    localparam int SAMPLE_W = 12;
    localparam int IQ_W = 15;
    localparam int WORD_W = 16;
    localparam int NUM_SAMP = 16;
    localparam int NUM_IQ = 8;
    localparam int NUM_FLAG = 4;
    localparam int LANES_PER_GROUP = 8;
    localparam int MODE_W = 7;
    localparam logic [6:0] MODE_SC_BYP_A = 7'h13;
    localparam logic [6:0] MODE_SC_BYP_B = 7'h2A;
    localparam logic [6:0] MODE_DC_BYP_A = 7'h14;
    localparam logic [6:0] MODE_DC_BYP_B = 7'h2B;
    localparam logic [6:0] MODE_D4_L4_A = 7'h15;
    localparam logic [6:0] MODE_D4_L4_B = 7'h24;
    localparam logic [6:0] MODE_D4_L8_A = 7'h16;
    localparam logic [6:0] MODE_D4_L8_B = 7'h2E;
    localparam logic [6:0] MODE_D8_L2_A = 7'h17;
    localparam logic [6:0] MODE_D8_L2_B = 7'h26;
    localparam logic [6:0] MODE_D8_L2_C = 7'h3D;
    localparam logic [6:0] MODE_D8_L2_D = 7'h40;
    localparam logic [6:0] MODE_D8_L2_E = 7'h45;
    localparam logic [6:0] MODE_D8_L2_F = 7'h47;
    localparam logic [6:0] MODE_D8_L4_A = 7'h18;
    localparam logic [6:0] MODE_D8_L4_B = 7'h30;
    localparam logic [6:0] MODE_D8_L4_C = 7'h3E;
    localparam logic [6:0] MODE_D8_L4_D = 7'h41;
    localparam logic [6:0] MODE_D8_L4_E = 7'h46;
    localparam logic [6:0] MODE_D4_L16_A = 7'h19;
    localparam logic [6:0] MODE_D4_L16_B = 7'h34;

    typedef enum logic [6:0] {
        MAP_NONE = 7'h01,
        MAP_BYP_SC = 7'h02,
        MAP_BYP_DC = 7'h04,
        MAP_IQ2 = 7'h08,
        MAP_IQ4 = 7'h10,
        MAP_IQ1 = 7'h20,
        MAP_IQ8 = 7'h40
    } lsp_map_type;

    typedef struct packed {
        logic [NUM_SAMP-1:0][SAMPLE_W-1:0] samp;
        logic [NUM_IQ-1:0][IQ_W-1:0] in_i;
        logic [NUM_IQ-1:0][IQ_W-1:0] in_q;
        logic [NUM_FLAG-1:0] overrange_flag_inphase;
        logic [NUM_FLAG-1:0] overrange_flag_quadrature;
    } lsp_in_type;

    typedef struct packed {
        logic [LANES_PER_GROUP-1:0][WORD_W-1:0] lane_group_a;
        logic [LANES_PER_GROUP-1:0][WORD_W-1:0] lane_group_b;
    } lsp_lanes_type;
endpackage

// file: rtl/lsp_packer.sv
/*
 * Lane sample packer: places samples, or I/Q samples with over-range
 * flags, onto the 16-bit words of lane groups A and B per link mode.
 * Assumes inputs come from logic on the same clock, one frame per valid.
 */
`timescale 1ns/10ps
module lsp_packer
    import lsp_pkg::*;
(
    // Clock, reset and enable
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic CE,
    // Configuration
    input wire logic [lsp_pkg::MODE_W-1:0] LINK_MODE_INDEX,
    // Frame in
    input wire logic IN_VALID,
    input wire lsp_pkg::lsp_in_type IN_DATA,
    // Lanes out
    output logic OUT_VALID,
    output lsp_pkg::lsp_lanes_type OUT_LANES
);
    import lsp_pkg::*;

    // ==========================================================
    // Mode decode
    // ==========================================================
    function automatic lsp_map_type decode_mode(input logic [MODE_W-1:0] m);
        unique case (m)
            MODE_SC_BYP_A, MODE_SC_BYP_B: decode_mode = MAP_BYP_SC;
            MODE_DC_BYP_A, MODE_DC_BYP_B: decode_mode = MAP_BYP_DC;
            MODE_D4_L4_A, MODE_D4_L4_B, MODE_D8_L4_A, MODE_D8_L4_B, MODE_D8_L4_C,
            MODE_D8_L4_D, MODE_D8_L4_E: decode_mode = MAP_IQ2;
            MODE_D4_L8_A, MODE_D4_L8_B: decode_mode = MAP_IQ4;
            MODE_D8_L2_A, MODE_D8_L2_B, MODE_D8_L2_C, MODE_D8_L2_D, MODE_D8_L2_E,
            MODE_D8_L2_F: decode_mode = MAP_IQ1;
            MODE_D4_L16_A, MODE_D4_L16_B: decode_mode = MAP_IQ8;
            default: decode_mode = MAP_NONE;
        endcase
    endfunction

    // Packs four 12-bit samples into three 16-bit words, MSB first.
    function automatic logic [3*WORD_W-1:0] pack4(input logic [SAMPLE_W-1:0] s0,
            input logic [SAMPLE_W-1:0] s1, input logic [SAMPLE_W-1:0] s2,
            input logic [SAMPLE_W-1:0] s3);
        pack4 = {s0, s1, s2, s3};
    endfunction

    wire lsp_map_type map_sel = decode_mode(LINK_MODE_INDEX);

    // ==========================================================
    // Lane word construction
    // ==========================================================
    logic [LANES_PER_GROUP-1:0][WORD_W-1:0] byp_sc_a, byp_sc_b, byp_dc_a, byp_dc_b;
    logic [LANES_PER_GROUP-1:0][WORD_W-1:0] iq_a, iq_b, iq8_a, iq8_b;
    logic [2:0][WORD_W-1:0] pk_sa0, pk_sa1, pk_sb0, pk_sb1, pk_da0, pk_da1, pk_db0, pk_db1;

    assign pk_sa0 = pack4(IN_DATA.samp[0], IN_DATA.samp[2], IN_DATA.samp[4], IN_DATA.samp[6]);
    assign pk_sa1 = pack4(IN_DATA.samp[8], IN_DATA.samp[10], IN_DATA.samp[12],
                          IN_DATA.samp[14]);
    assign pk_sb0 = pack4(IN_DATA.samp[1], IN_DATA.samp[3], IN_DATA.samp[5], IN_DATA.samp[7]);
    assign pk_sb1 = pack4(IN_DATA.samp[9], IN_DATA.samp[11], IN_DATA.samp[13],
                          IN_DATA.samp[15]);
    assign pk_da0 = pack4(IN_DATA.samp[0], IN_DATA.samp[1], IN_DATA.samp[2], IN_DATA.samp[3]);
    assign pk_da1 = pack4(IN_DATA.samp[4], IN_DATA.samp[5], IN_DATA.samp[6], IN_DATA.samp[7]);
    assign pk_db0 = pack4(IN_DATA.samp[8], IN_DATA.samp[9], IN_DATA.samp[10],
                          IN_DATA.samp[11]);
    assign pk_db1 = pack4(IN_DATA.samp[12], IN_DATA.samp[13], IN_DATA.samp[14],
                          IN_DATA.samp[15]);

    genvar g;
    generate
        for (g = 0; g < LANES_PER_GROUP; g++) begin : g_lane
            // The top word (index 2) of a packed triple sits on the lowest lane of the three.
            if (g < 3) begin : g_lo
                assign byp_sc_a[g] = pk_sa0[2-g];
                assign byp_sc_b[g] = pk_sb0[2-g];
                assign byp_dc_a[g] = pk_da0[2-g];
                assign byp_dc_b[g] = pk_db0[2-g];
            end else if (g < 6) begin : g_hi
                assign byp_sc_a[g] = pk_sa1[5-g];
                assign byp_sc_b[g] = pk_sb1[5-g];
                assign byp_dc_a[g] = pk_da1[5-g];
                assign byp_dc_b[g] = pk_db1[5-g];
            end else begin : g_unused
                assign byp_sc_a[g] = '0;
                assign byp_sc_b[g] = '0;
                assign byp_dc_a[g] = '0;
                assign byp_dc_b[g] = '0;
            end
            // I on A, Q on B
            if (g < NUM_FLAG) begin : g_iq
                assign iq_a[g] = {IN_DATA.in_i[g], IN_DATA.overrange_flag_inphase[g]};
                assign iq_b[g] = {IN_DATA.in_q[g], IN_DATA.overrange_flag_quadrature[g]};
            end else begin : g_iq_none
                assign iq_a[g] = '0;
                assign iq_b[g] = '0;
            end
            assign iq8_a[g] = {IN_DATA.in_i[g], IN_DATA.overrange_flag_inphase[g/2]};
            assign iq8_b[g] = {IN_DATA.in_q[g], IN_DATA.overrange_flag_quadrature[g/2]};
        end
    endgenerate

    // Lanes beyond the mode's count are zeroed so unused lanes stay quiet.
    function automatic logic [LANES_PER_GROUP-1:0][WORD_W-1:0] keep(
            input logic [LANES_PER_GROUP-1:0][WORD_W-1:0] w, input int n);
        keep = '0;
        for (int k = 0; k < LANES_PER_GROUP; k++) begin
            if (k < n) begin
                keep[k] = w[k];
            end
        end
    endfunction

    lsp_lanes_type lanes_d, lanes_q;
    logic valid_q;

    always_comb begin
        lanes_d = '0;
        unique case (map_sel)
            MAP_BYP_SC: begin
                lanes_d.lane_group_a = byp_sc_a;
                lanes_d.lane_group_b = byp_sc_b;
            end
            MAP_BYP_DC: begin
                lanes_d.lane_group_a = byp_dc_a;
                lanes_d.lane_group_b = byp_dc_b;
            end
            MAP_IQ1: begin
                lanes_d.lane_group_a = keep(iq_a, 1);
                lanes_d.lane_group_b = keep(iq_b, 1);
            end
            MAP_IQ2: begin
                lanes_d.lane_group_a = keep(iq_a, 2);
                lanes_d.lane_group_b = keep(iq_b, 2);
            end
            MAP_IQ4: begin
                lanes_d.lane_group_a = iq_a;
                lanes_d.lane_group_b = iq_b;
            end
            MAP_IQ8: begin
                lanes_d.lane_group_a = iq8_a;
                lanes_d.lane_group_b = iq8_b;
            end
            MAP_NONE: begin
                lanes_d = '0;
            end
        endcase
    end

    // ==========================================================
    // Output registers
    // ==========================================================
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            lanes_q <= '0;
            valid_q <= 1'b0;
        end else if (CE) begin
            lanes_q <= IN_VALID ? lanes_d : lanes_q;
            valid_q <= IN_VALID && (map_sel != MAP_NONE);
        end
    end

    assign OUT_LANES = lanes_q;
    assign OUT_VALID = valid_q;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_sc_even_lane: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_BYP_SC |=>
        OUT_LANES.lane_group_a[0][15:4] == $past(IN_DATA.samp[0]))
        else $error("single bypass lane A0 wrong");
    chk_pack_tail: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_BYP_SC |=>
        OUT_LANES.lane_group_b[5][11:0] == $past(IN_DATA.samp[15]))
        else $error("packed tail sample wrong");
    chk_dc_chan_b: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_BYP_DC |=>
        OUT_LANES.lane_group_b[0][15:4] == $past(IN_DATA.samp[8]))
        else $error("dual bypass channel B wrong");
    chk_dc_order: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_BYP_DC |=>
        OUT_LANES.lane_group_a[4][15:8] == $past(IN_DATA.samp[5][7:0]))
        else $error("dual bypass order wrong");
    chk_iq2_q: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_IQ2 |=>
        OUT_LANES.lane_group_b[1] == {$past(IN_DATA.in_q[1]),
        $past(IN_DATA.overrange_flag_quadrature[1])} && OUT_LANES.lane_group_a[2] == '0)
        else $error("four lane IQ wrong");
    chk_iq4_flag: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_IQ4 |=>
        OUT_LANES.lane_group_a[3][0] == $past(IN_DATA.overrange_flag_inphase[3]))
        else $error("eight lane flag wrong");
    chk_iq1_only: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_IQ1 |=>
        OUT_LANES.lane_group_a[0][15:1] == $past(IN_DATA.in_i[0])
        && OUT_LANES.lane_group_b[1] == '0)
        else $error("two lane IQ wrong");
    chk_iq2_in_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_IQ2 |=>
        OUT_LANES.lane_group_a[1] == {$past(IN_DATA.in_i[1]),
        $past(IN_DATA.overrange_flag_inphase[1])})
        else $error("four lane in-phase wrong");
    chk_iq8_share: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID && map_sel == MAP_IQ8 |=>
        OUT_LANES.lane_group_b[5][0] == $past(IN_DATA.overrange_flag_quadrature[2]))
        else $error("sixteen lane flag share wrong");
    chk_mode_valid: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && IN_VALID |=> OUT_VALID == ($past(map_sel) != MAP_NONE))
        else $error("valid not tied to mode");
endmodule

// file: test/lsp_packer_tb.sv
/*
 * Self-checking bench for the lane sample packer across all link modes.
 * Assumes lsp_pkg, the packer and the receiver model are compiled first.
 */
`timescale 1ns/10ps
module lsp_packer_tb;
    import lsp_pkg::*;
    logic CLK_SYS = 1'b0;
    logic NRST = 1'b0;
    logic CE = 1'b1;
    logic [MODE_W-1:0] LINK_MODE_INDEX = '0;
    logic IN_VALID = 1'b0;
    lsp_in_type IN_DATA = '0;
    logic OUT_VALID;
    lsp_lanes_type OUT_LANES;
    lsp_lanes_type last_e = '0;
    int rx_count;
    logic [IQ_W-1:0] rx_first;
    logic [IQ_W-1:0] last_first = '0;
    logic last_v = 1'b0;
    int n_fail = 0;
    int check_count = 0;
    int n_sent = 0;
    int modes[23] = '{19, 42, 20, 43, 21, 36, 22, 46, 23, 38, 61, 64, 69, 71,
                      24, 48, 62, 65, 70, 25, 52, 0, 127};

    always #2.5 CLK_SYS = ~CLK_SYS;

    lsp_packer i_lsp_packer(.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE),
        .LINK_MODE_INDEX(LINK_MODE_INDEX), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
        .OUT_VALID(OUT_VALID), .OUT_LANES(OUT_LANES));
    // A frozen valid stays high while CE is low, so the receiver takes it only with CE.
    lsp_rx_model i_lsp_rx_model(.clk(CLK_SYS), .nrst(NRST), .lanes_valid(OUT_VALID && CE),
        .lanes(OUT_LANES), .rx_first_q(rx_first), .rx_count_q(rx_count));

    // ==========================================================
    // Expected lane layout
    function automatic int iq_lanes(int m);
        if (m inside {21, 36, 24, 48, 62, 65, 70}) return 2;
        if (m inside {22, 46}) return 4;
        if (m inside {23, 38, 61, 64, 69, 71}) return 1;
        if (m inside {25, 52}) return 8;
        return 0;
    endfunction

    function automatic lsp_lanes_type expect_lanes(int m, lsp_in_type d);
        lsp_lanes_type r;
        logic [47:0] t;
        int n;
        r = '0;
        n = iq_lanes(m);
        if (m inside {19, 42, 20, 43}) begin
            for (int g = 0; g < 2; g++) begin
                for (int k = 0; k < 2; k++) begin
                    for (int j = 0; j < 4; j++) begin
                        t[47-12*j -: 12] = (m inside {20, 43}) ? d.samp[g*8+k*4+j]
                                                               : d.samp[2*(k*4+j)+g];
                    end
                    for (int w = 0; w < 3; w++) begin
                        if (g == 0) r.lane_group_a[k*3+w] = t[47-16*w -: 16];
                        else r.lane_group_b[k*3+w] = t[47-16*w -: 16];
                    end
                end
            end
        end
        for (int k = 0; k < n; k++) begin
            r.lane_group_a[k] = {d.in_i[k], d.overrange_flag_inphase[n == 8 ? k / 2 : k]};
            r.lane_group_b[k] = {d.in_q[k], d.overrange_flag_quadrature[n == 8 ? k / 2 : k]};
        end
        return r;
    endfunction

    function automatic lsp_in_type rand_frame();
        logic [447:0] v;
        for (int i = 0; i < 14; i++) v[i*32 +: 32] = $urandom();
        return v[$bits(lsp_in_type)-1:0];
    endfunction

    // ==========================================================
    // Compare and report
    task automatic cmp_bit(logic g, logic e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_lanes(lsp_lanes_type g, lsp_lanes_type e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_word(logic [IQ_W-1:0] g, logic [IQ_W-1:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_int(int g, int e);
        check_count++;
        if (g != e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Drives one frame, leaves valid high so frames run back to back.
    task automatic step(int m, lsp_in_type d, logic ce);
        lsp_lanes_type e;
        logic ev;
        e = ce ? expect_lanes(m, d) : last_e;
        ev = ce ? (iq_lanes(m) != 0 || m inside {19, 42, 20, 43}) : last_v;
        LINK_MODE_INDEX = m[MODE_W-1:0];
        IN_DATA = d;
        IN_VALID = 1'b1;
        CE = ce;
        @(posedge CLK_SYS);
        #1;
        cmp_bit(OUT_VALID, ev);
        cmp_lanes(OUT_LANES, e);
        if (ce && ev) begin
            n_sent++;
            last_first = e.lane_group_a[0][WORD_W-1:1];
        end
        last_e = e;
        last_v = ev;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(66));
        repeat (4) @(posedge CLK_SYS);
        #1;
        NRST = 1'b1;
        foreach (modes[i]) begin
            for (int r = 0; r < 4; r++) begin
                step(modes[i], (r == 0) ? '1 : rand_frame(), r != 2);
            end
        end
        cmp_int(rx_count, n_sent);
        cmp_word(rx_first, last_first);
        NRST = 1'b0;
        IN_VALID = 1'b0;
        @(posedge CLK_SYS);
        #1;
        cmp_bit(OUT_VALID, 1'b0);
        cmp_lanes(OUT_LANES, '0);
        NRST = 1'b1;
        step(25, rand_frame(), 1'b1);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge CLK_SYS);
        n_fail++;
        report_and_stop();
    end
endmodule

// file: test/lsp_rx_model.sv
/*
 * Receiver-side model of the lane sample packer's far end.
 * Assumes it shares the packer clock and sees the registered lane outputs.
 * Its valid input is already qualified by the packer's clock enable.
 */
`timescale 1ns/10ps
module lsp_rx_model
    import lsp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Lanes from the packer
    input wire logic lanes_valid,
    input wire lsp_pkg::lsp_lanes_type lanes,
    // Unpacked view
    output logic [IQ_W-1:0] rx_first_q,
    output int rx_count_q
);
    // ==========================================================
    // Frame capture
    // Receiver counts and unpacks frames.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_first_q <= '0;
            rx_count_q <= 0;
        end else if (lanes_valid) begin
            rx_first_q <= lanes.lane_group_a[0][WORD_W-1:1];
            rx_count_q <= rx_count_q + 1;
        end
    end
endmodule
